// >>> include/bssm_pkg.sv
// What this block does
// - Internal state bit 3 flags load/store access.
// - Internal state bit 2: read 0, write 1.
// - Internal bits 1:0 encode access width.
// - Without access, internal bits and address invalid.
// - External bit 5: burst 0, cycle steal 1.
// - External bit 4: CPU 0, DMA 1.
// - External bits 6,3,2 encode DMA transfer unit.
// - External bit 1: read 0, write 1.
// - External bit 0 flags access; else invalid.
// - Match flags for channels A, B, conditions 1-4.
// - Sequential A flag: A matched, B not yet.
// - Four-stage: condition 4 sequential flag behaviour.
// - Three/four-stage: condition 3 sequential flag behaviour.
// - Two/three/four-stage: condition 2 sequential flag behaviour.
// - Condition match flags clear after a break.
// - Plain unit mode: channel flags stay until cleared.
// - In sleep only status pins, ratio readable.
// - Performance counter 48 bits, invalid after overflow.
package bssm_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W       = 8;
   localparam logic [7:0]  OFF_CTRL     = 8'h00;
   localparam logic [7:0]  OFF_INT_ST   = 8'h04;
   localparam logic [7:0]  OFF_INT_ADDR = 8'h08;
   localparam logic [7:0]  OFF_EXT_ST   = 8'h0c;
   localparam logic [7:0]  OFF_EXT_ADDR = 8'h10;
   localparam logic [7:0]  OFF_FLAGS    = 8'h14;
   localparam logic [7:0]  OFF_STATUS   = 8'h18;
   localparam logic [7:0]  OFF_RATIO    = 8'h1c;
   localparam logic [7:0]  OFF_PERF_LO  = 8'h20;
   localparam logic [7:0]  OFF_PERF_HI  = 8'h24;

   // ------------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------------
   localparam int unsigned CTRL_HOLD    = 0;
   localparam int unsigned CTRL_SEQ_LO  = 1;
   localparam int unsigned CTRL_SEQ_HI  = 2;
   localparam int unsigned CTRL_AB_SEQ  = 3;
   localparam int unsigned CTRL_AB_PLN  = 4;
   localparam int unsigned CTRL_PERF_EN = 5;
   localparam int unsigned CTRL_FLG_CLR = 8;
   localparam int unsigned CTRL_PRF_CLR = 9;
   localparam logic [7:0]  CTRL_RST     = 8'h00;

   // Sequential mode codes held in the control seq field.
   localparam logic [1:0]  SEQ_NONE     = 2'h0;
   localparam logic [1:0]  SEQ_TWO      = 2'h1;
   localparam logic [1:0]  SEQ_THREE    = 2'h2;
   localparam logic [1:0]  SEQ_FOUR     = 2'h3;

   // ------------------------------------------------------------------
   // Field layouts and widths
   // ------------------------------------------------------------------
   localparam int unsigned INT_ACC      = 3;
   localparam int unsigned EXT_UNIT2    = 6;
   localparam int unsigned EXT_STEAL    = 5;
   localparam int unsigned EXT_DMA      = 4;
   localparam int unsigned EXT_ACC      = 0;
   localparam int unsigned FLG_SEQ_LO   = 6;
   localparam int unsigned PERF_W       = 48;
   localparam int unsigned PERF_OVF_BIT = 31;
   localparam int unsigned STAT_W       = 2;
   localparam int unsigned RATIO_W      = 16;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage : bssm_pkg

// >>> rtl/bssm_top.sv
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module bssm_top (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic                          ce,
   // AXI4-Lite slave.
   input  wire logic                          awvalid,
   output      logic                          awready,
   input  wire logic [bssm_pkg::ADDR_W-1:0]   awaddr,
   input  wire logic [2:0]                    awprot,
   input  wire logic                          wvalid,
   output      logic                          wready,
   input  wire logic [31:0]                   wdata,
   input  wire logic [3:0]                    wstrb,
   output      logic                          bvalid,
   input  wire logic                          bready,
   output      logic [1:0]                    bresp,
   input  wire logic                          arvalid,
   output      logic                          arready,
   input  wire logic [bssm_pkg::ADDR_W-1:0]   araddr,
   input  wire logic [2:0]                    arprot,
   output      logic                          rvalid,
   input  wire logic                          rready,
   output      logic [31:0]                   rdata,
   output      logic [1:0]                    rresp,
   // Load/store bus observation.
   input  wire logic                          ib_access,
   input  wire logic                          ib_write,
   input  wire logic [1:0]                    ib_width,
   input  wire logic [31:0]                   ib_addr,
   // External bus observation.
   input  wire logic                          eb_access,
   input  wire logic                          eb_write,
   input  wire logic                          eb_dma,
   input  wire logic                          eb_cycle_steal,
   input  wire logic [2:0]                    eb_unit,
   input  wire logic [31:0]                   eb_addr,
   // Break unit events.
   input  wire logic                          break_a_match,
   input  wire logic                          break_b_match,
   input  wire logic [3:0]                    break_cond_match,
   input  wire logic                          break_taken,
   // Power state, pins, clock ratio and performance event.
   input  wire logic                          sleep_mode,
   input  wire logic [bssm_pkg::STAT_W-1:0]   status_pins,
   input  wire logic [bssm_pkg::RATIO_W-1:0]  clock_ratio_control,
   input  wire logic                          perf_event
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic                          aw_got;
      logic [bssm_pkg::ADDR_W-1:0]   aw_addr;
      logic                          w_got;
      logic [31:0]                   w_data;
      logic [3:0]                    w_strb;
      logic                          bvalid;
      logic [1:0]                    bresp;
      logic                          rvalid;
      logic [31:0]                   rdata;
      logic [1:0]                    rresp;
      logic [7:0]                    ctrl;
      logic [3:0]                    int_st;
      logic [31:0]                   int_addr;
      logic [6:0]                    ext_st;
      logic [31:0]                   ext_addr;
      logic [5:0]                    flag;
      logic [3:0]                    seq;
      logic [bssm_pkg::STAT_W-1:0]   stat_s1;
      logic [bssm_pkg::STAT_W-1:0]   stat_s2;
      logic [bssm_pkg::STAT_W-1:0]   stat;
      logic [bssm_pkg::RATIO_W-1:0]  ratio;
      logic [bssm_pkg::PERF_W-1:0]   perf;
      logic                          perf_ovf;
   } bssm_state_t;

   bssm_state_t q;
   bssm_state_t d;

   logic [5:0]                   ev;
   logic [5:0]                   flag_clr;
   logic                         sw_flag_clr;
   logic                         sw_perf_clr;
   logic [bssm_pkg::PERF_W:0]    perf_sum;
   logic [33:0]                  rd;

   // ------------------------------------------------------------------
   // Read decode
   // ------------------------------------------------------------------
   // Returns {resp, data}. In sleep only status pins and ratio answer.
   function automatic logic [33:0] read_reg(input bssm_state_t s,
                                            input logic [bssm_pkg::ADDR_W-1:0] a,
                                            input logic slp);
      logic [31:0] v;
      logic [1:0]  r;
      v = 32'h0000_0000;
      r = bssm_pkg::RESP_OKAY;
      case (a)
         bssm_pkg::OFF_CTRL:     v = {24'h00_0000, s.ctrl};
         bssm_pkg::OFF_INT_ST:   v = {28'h000_0000, s.int_st};
         bssm_pkg::OFF_INT_ADDR: v = s.int_addr;
         bssm_pkg::OFF_EXT_ST:   v = {25'h000_0000, s.ext_st};
         bssm_pkg::OFF_EXT_ADDR: v = s.ext_addr;
         bssm_pkg::OFF_FLAGS:    v = {22'h00_0000, s.seq, s.flag};
         bssm_pkg::OFF_STATUS:   v = {30'h0000_0000, s.stat};
         bssm_pkg::OFF_RATIO:    v = {16'h0000, s.ratio};
         bssm_pkg::OFF_PERF_LO:  v = s.perf[31:0];
         bssm_pkg::OFF_PERF_HI:  v = {s.perf_ovf, 15'h0000, s.perf[47:32]};
         default:                r = bssm_pkg::RESP_SLVERR;
      endcase
      if (slp && a != bssm_pkg::OFF_STATUS && a != bssm_pkg::OFF_RATIO) begin
         v = 32'h0000_0000;
      end
      return {r, v};
   endfunction : read_reg

   // ------------------------------------------------------------------
   // Bus handshake outputs
   // ------------------------------------------------------------------
   assign awready = ce & ~q.aw_got & ~q.bvalid;
   assign wready  = ce & ~q.w_got & ~q.bvalid;
   assign arready = ce & ~q.rvalid;
   assign bvalid  = q.bvalid;
   assign bresp   = q.bresp;
   assign rvalid  = q.rvalid;
   assign rdata   = q.rdata;
   assign rresp   = q.rresp;

   assign rd       = read_reg(q, araddr, sleep_mode);
   assign ev       = {break_cond_match, break_b_match, break_a_match};
   assign perf_sum = {1'b0, q.perf} + 49'h0_0000_0000_0001;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      d           = q;
      sw_flag_clr = 1'b0;
      sw_perf_clr = 1'b0;

      // Write channel: address and data are taken in either order.
      if (awvalid && awready) begin
         d.aw_got  = 1'b1;
         d.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         d.w_got  = 1'b1;
         d.w_data = wdata;
         d.w_strb = wstrb;
      end
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end
      if (d.aw_got && d.w_got && !q.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = bssm_pkg::RESP_OKAY;
         if (d.aw_addr == bssm_pkg::OFF_CTRL) begin
            if (d.w_strb[0]) begin
               d.ctrl = d.w_data[7:0];
            end
            if (d.w_strb[1]) begin
               sw_flag_clr = d.w_data[bssm_pkg::CTRL_FLG_CLR];
               sw_perf_clr = d.w_data[bssm_pkg::CTRL_PRF_CLR];
            end
         end else if (d.aw_addr[1:0] != 2'h0 || d.aw_addr > bssm_pkg::OFF_PERF_HI) begin
            d.bresp = bssm_pkg::RESP_SLVERR;
         end
      end

      // Read channel: data is the register contents at the accepting edge.
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         d.rvalid = 1'b1;
         d.rresp  = rd[33:32];
         d.rdata  = rd[31:0];
      end

      // Status pins pass three flip-flops; pins and ratio stay live in sleep.
      d.stat_s1 = status_pins;
      d.stat_s2 = q.stat_s1;
      if (!q.ctrl[bssm_pkg::CTRL_HOLD]) begin
         d.stat  = q.stat_s2;
         d.ratio = clock_ratio_control;
      end

      // One-cycle capture of every bus field, suppressed in sleep.
      if (!q.ctrl[bssm_pkg::CTRL_HOLD] && !sleep_mode) begin
         d.int_st   = ib_access ? {1'b1, ib_write, ib_width} : 4'h0;
         d.int_addr = ib_access ? ib_addr : 32'h0000_0000;
         if (eb_access) begin
            d.ext_st = {eb_dma & eb_unit[2], eb_dma & eb_cycle_steal, eb_dma,
                        eb_unit[1:0], eb_write, 1'b1};
            d.ext_addr = eb_addr;
         end else begin
            d.ext_st   = 7'h00;
            d.ext_addr = 32'h0000_0000;
         end
      end

      // Match flags: a new match wins over a clear in the same cycle.
      flag_clr[1:0] = q.ctrl[bssm_pkg::CTRL_AB_PLN] ? {2{sw_flag_clr}}
                                                    : {2{break_taken}};
      flag_clr[5:2] = {4{break_taken}};
      d.flag = (q.flag & ~flag_clr) | ev;

      // Sequential flags: set by own condition, cleared by a break and by B (A flag) or by the preceding condition.
      if (q.ctrl[bssm_pkg::CTRL_AB_SEQ]) begin
         d.seq[0] = break_a_match | (q.seq[0] & ~break_b_match & ~break_taken);
      end else begin
         d.seq[0] = 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
         if (q.ctrl[bssm_pkg::CTRL_SEQ_HI:bssm_pkg::CTRL_SEQ_LO] > 2'(i)) begin
            d.seq[i+1] = break_cond_match[i+1]
                       | (q.seq[i+1] & ~break_cond_match[i] & ~break_taken);
         end else begin
            d.seq[i+1] = 1'b0;
         end
      end

      // Performance counter; overflow is sticky until cleared.
      if (sw_perf_clr) begin
         d.perf = '0;
      end else if (q.ctrl[bssm_pkg::CTRL_PERF_EN] && perf_event) begin
         d.perf = perf_sum[bssm_pkg::PERF_W-1:0];
      end
      d.perf_ovf = (q.ctrl[bssm_pkg::CTRL_PERF_EN] & perf_event & perf_sum[bssm_pkg::PERF_W])
                 | (q.perf_ovf & ~sw_perf_clr);
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q      <= '0;
         q.ctrl <= bssm_pkg::CTRL_RST;
      end else if (ce) begin
         q <= d;
      end
   end

endmodule : bssm_top

// >>> tb/bssm_properties.sv
`timescale 1ns/100ps
module bssm_properties (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [1:0]  bresp,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [7:0]  araddr,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        ib_access,
   input wire logic        eb_access,
   input wire logic        sleep_mode
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_resp; awvalid && awready && wvalid && wready |=> bvalid; endproperty
   a_b_resp: assert property (p_b_resp) else $error("write response late");
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_resp; arvalid && arready |=> rvalid; endproperty
   a_r_resp: assert property (p_r_resp) else $error("read response late");
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_ar_block; rvalid |-> !arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read accepted while busy");
   property p_int_inv; arvalid && arready && araddr inside {8'h04, 8'h08} && !ib_access
      && !$past(ib_access) && !$past(ib_access, 2) |=> rdata == 32'h0; endproperty
   a_int_inv: assert property (p_int_inv) else $error("stale internal state");
   property p_ext_inv; arvalid && arready && araddr inside {8'h0c, 8'h10} && !eb_access
      && !$past(eb_access) && !$past(eb_access, 2) |=> rdata == 32'h0; endproperty
   a_ext_inv: assert property (p_ext_inv) else $error("stale external state");
   property p_sleep; arvalid && arready && sleep_mode && araddr == 8'h0c |=> rdata == 32'h0
      && rresp == 2'h0; endproperty
   a_sleep: assert property (p_sleep) else $error("item readable in sleep");
   property p_bad; arvalid && arready && araddr == 8'h40 |=> rresp == 2'h2; endproperty
   a_bad: assert property (p_bad) else $error("unmapped read not refused");
endmodule : bssm_properties
bind bssm_top bssm_properties chk_u (.*);

// >>> tb/bssm_emu_model.sv
`timescale 1ns/100ps
module bssm_emu_model #(
   parameter int unsigned REFRESH_MS = 1000
) (
   input  wire logic        aclk,
   input  wire logic        awready,
   input  wire logic        wready,
   input  wire logic        bvalid,
   input  wire logic [1:0]  bresp,
   input  wire logic        arready,
   input  wire logic        rvalid,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   output logic             awvalid,
   output logic [7:0]       awaddr,
   output logic             wvalid,
   output logic [31:0]      wdata,
   output logic             bready,
   output logic             arvalid,
   output logic [7:0]       araddr,
   output logic             rready
);
   int irq_held = 0;
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
   end
   // Called right after a rising edge; holds each channel until taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      forever begin
         @(posedge aclk);
         if (bvalid === 1'b1) break;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end
      r = bresp;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      forever begin
         @(posedge aclk);
         if (rvalid === 1'b1) break;
         if (arready === 1'b1) arvalid <= 1'b0;
      end
      d = rdata;
      r = rresp;
   endtask : rd
   // An interrupt that arrives while no command runs is only counted here in irq_held.
   task automatic park_irq();
      irq_held++;
   endtask : park_irq
   // A count is shown as one 32-bit word, or only as the overflow marker.
   function automatic logic [32:0] count_view(input logic [31:0] hi, input logic [31:0] lo);
      return hi[bssm_pkg::PERF_OVF_BIT] ? {1'b1, 32'h0000_0000} : {1'b0, lo};
   endfunction : count_view
endmodule : bssm_emu_model

// >>> tb/test_bssm_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("FAIL %0t got %h exp %h", $time, g, e); end end
module test_bssm_top;
   logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, ib_access, ib_write, eb_access, eb_write;
   logic        eb_dma, eb_cycle_steal, break_a_match, break_b_match, break_taken, sleep_mode;
   logic        perf_event;
   logic [1:0]  bresp, rresp, ib_width, status_pins, resp;
   logic [2:0]  awprot, arprot, eb_unit;
   logic [3:0]  wstrb, break_cond_match;
   logic [7:0]  awaddr, araddr;
   logic [15:0] clock_ratio_control;
   logic [31:0] wdata, rdata, ib_addr, eb_addr, rd, seed, r;
   int          err_count, num_checks, flags, mode;
   int          seq_q[$] = '{5, 4, 5, 3, 2, 0, 1};
   bssm_top dut_u (.*);
   bssm_emu_model emu_u (.*);
   initial aclk = 1'b0;
   always #12.5 aclk = ~aclk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      emu_u.rd(a, rd, resp);
      `CHK(rd, e)
      `CHK(resp, bssm_pkg::RESP_OKAY)
   endtask : rchk
   // Pulses one event (6 is a break) and updates the reference flags.
   task automatic ev(input int i);
      {break_taken, break_cond_match, break_b_match, break_a_match} <= 7'(1 << i);
      @(posedge aclk);
      {break_taken, break_cond_match, break_b_match, break_a_match} <= 7'h0;
      @(posedge aclk);
      if (i < 6) flags |= 1 << i;
      if (i == 0 && mode[3]) flags |= 1 << 6;
      if (i == 1) flags &= ~(1 << 6);
      if (i >= 3 && i <= 5 && mode[2:1] >= i - 2) flags |= 1 << (i + 4);
      if (i >= 2 && i <= 4) flags &= ~(1 << (i + 5));
      if (i == 6) flags &= mode[4] ? 3 : 0;
   endtask : ev
   initial begin
      seed = 32'h4832;
      {aresetn, ib_access, ib_write, ib_width, eb_access, eb_write, eb_dma} = '0;
      {eb_cycle_steal, eb_unit, break_a_match, break_b_match, break_cond_match} = '0;
      {break_taken, sleep_mode, status_pins, perf_event, awprot, arprot} = '0;
      {ib_addr, eb_addr, clock_ratio_control, flags, mode} = '0;
      ce = 1'b1;
      wstrb = 4'hf;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rchk(bssm_pkg::OFF_CTRL, 32'h0);
      emu_u.rd(8'h40, rd, resp);
      `CHK(resp, bssm_pkg::RESP_SLVERR)
      emu_u.wr(8'h40, 32'h0, resp);
      `CHK(resp, bssm_pkg::RESP_SLVERR)
      for (int k = 0; k < 8; k++) begin
         {ib_access, ib_write, ib_width} <= {1'b1, 3'(k)};
         ib_addr <= rnd();
         repeat (2) @(posedge aclk);
         rchk(bssm_pkg::OFF_INT_ST, {28'h1, 3'(k)});
         rchk(bssm_pkg::OFF_INT_ADDR, ib_addr);
      end
      ib_access <= 1'b0;
      repeat (3) @(posedge aclk);
      rchk(bssm_pkg::OFF_INT_ST, 32'h0);
      rchk(bssm_pkg::OFF_INT_ADDR, 32'h0);
      $display("internal bus test done");
      for (int k = 0; k < 32; k++) begin
         r = rnd();
         r[5:1] = 5'(k);
         {eb_cycle_steal, eb_dma, eb_write, eb_unit} <= {r[2:0], r[5:3]};
         {eb_access, eb_addr} <= {1'b1, r};
         repeat (2) @(posedge aclk);
         rchk(bssm_pkg::OFF_EXT_ST,
              {r[1] & r[5], r[1] & r[2], r[1], r[4:3], r[0], 1'b1});
         rchk(bssm_pkg::OFF_EXT_ADDR, r);
      end
      eb_access <= 1'b0;
      repeat (3) @(posedge aclk);
      rchk(bssm_pkg::OFF_EXT_ST, 32'h0);
      $display("external bus test done");
      for (int i = 0; i < 7; i++) begin
         ev(i);
         rchk(bssm_pkg::OFF_FLAGS, flags);
      end
      mode = 32'h10;
      emu_u.wr(bssm_pkg::OFF_CTRL, mode, resp);
      foreach (seq_q[j]) ev(j % 2);
      ev(6);
      rchk(bssm_pkg::OFF_FLAGS, flags);
      emu_u.wr(bssm_pkg::OFF_CTRL, 32'h100, resp);
      {mode, flags} = '0;
      rchk(bssm_pkg::OFF_FLAGS, 32'h0);
      for (int m = 0; m < 4; m++) begin
         mode = m * 2 + 8;
         emu_u.wr(bssm_pkg::OFF_CTRL, mode, resp);
         foreach (seq_q[j]) begin
            ev(seq_q[j]);
            rchk(bssm_pkg::OFF_FLAGS, flags);
         end
         ev(6);
         rchk(bssm_pkg::OFF_FLAGS, 32'h0);
      end
      $display("flag test done");
      r = rnd();
      {eb_access, eb_addr} <= {1'b1, r};
      @(posedge aclk);
      {status_pins, clock_ratio_control, sleep_mode} <= {r[17:0], 1'b1};
      repeat (4) @(posedge aclk);
      rchk(bssm_pkg::OFF_STATUS, r[17:16]);
      rchk(bssm_pkg::OFF_RATIO, r[15:0]);
      rchk(bssm_pkg::OFF_EXT_ST, 32'h0);
      rchk(bssm_pkg::OFF_EXT_ADDR, 32'h0);
      {sleep_mode, eb_access} <= 2'h0;
      emu_u.wr(bssm_pkg::OFF_CTRL, 32'h20, resp);
      perf_event <= 1'b1;
      repeat (5) @(posedge aclk);
      ce <= 1'b0;
      repeat (3) @(posedge aclk);
      {ce, perf_event} <= 2'h2;
      @(posedge aclk);
      rchk(bssm_pkg::OFF_PERF_LO, 32'h5);
      rchk(bssm_pkg::OFF_PERF_HI, 32'h0);
      emu_u.rd(bssm_pkg::OFF_PERF_LO, r, resp);
      `CHK(emu_u.count_view(rd, r), 33'h0_0000_0005)
      emu_u.wr(bssm_pkg::OFF_CTRL, 32'h201, resp);
      {ib_access, ib_addr} <= {1'b1, rnd()};
      repeat (2) @(posedge aclk);
      rchk(bssm_pkg::OFF_PERF_LO, 32'h0);
      rchk(bssm_pkg::OFF_INT_ADDR, 32'h0);
      emu_u.park_irq();
      emu_u.park_irq();
      `CHK(emu_u.irq_held, 2)
      `CHK(emu_u.REFRESH_MS inside {[1000:65535]}, 1'b1)
      $display("sleep and count test done");
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      $display("FAIL %0t watchdog expired", $time);
      end_of_test();
   end
endmodule : test_bssm_top
